// >>> asr_host.sv
// Host controller that runs byte reads and writes on an asynchronous SRAM.
`default_nettype none
// Notes on behaviour
// - Address stable before write strobe rises.
// - Both selects active before write ends.
// - Host never drives against memory output.
// - Active-high select held solid during power-down.
// - Deselect no later than supply falls; the host deselects on the first clock edge that samples supplyOk low.
// - Wait recovery time after supply returns.

module asr_host
    import asr_pkg::*;
#(
    parameter bit FAST_GRADE    = 1'b1,
    parameter int RECOVER_CYC   = asr_pkg::PD_RECOVER_CYC,
    parameter int TIMER_W       = 16
) (
    input  wire logic                     sys_clk,    // System clock.
    input  wire logic                     srst,       // Synchronous reset.
    input  wire logic                     reqValid,   // Request offered.
    input  wire asr_pkg::asr_req_t        reqIn,      // Request fields.
    output logic                          reqReady,   // Request taken.
    output logic                          doneValid,  // Access finished.
    output logic                          doneWrite,  // Finished one wrote.
    output logic [asr_pkg::DATA_W-1:0]    rdData,     // Read byte.
    input  wire logic                     supplyOk,   // Supply in range.
    output logic                          memReady,   // Memory usable.
    output asr_pkg::asr_pins_t            pins,       // SRAM pin drive.
    input  wire logic [asr_pkg::DATA_W-1:0] dqIn      // SRAM byte lines.
);

    import asr_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Phase lengths for the chosen grade.
    localparam int RD_NS = FAST_GRADE ?
        max2(T_CR_FAST_NS, max2(T_ACC_ADDR_FAST_NS,
             max2(T_ACC_SEL_FAST_NS, T_ACC_OE_FAST_NS))) :
        max2(T_CR_SLOW_NS, max2(T_ACC_ADDR_SLOW_NS,
             max2(T_ACC_SEL_SLOW_NS, T_ACC_OE_SLOW_NS)));
    localparam int WP_NS = FAST_GRADE ?
        max2(T_WP_FAST_NS, max2(T_SU_AWH_FAST_NS,
             max2(T_SU_SEL_FAST_NS, T_SU_D_FAST_NS))) :
        max2(T_WP_SLOW_NS, max2(T_SU_AWH_SLOW_NS,
             max2(T_SU_SEL_SLOW_NS, T_SU_D_SLOW_NS)));
    localparam int DIS_NS = FAST_GRADE ? T_DIS_FAST_NS : T_DIS_SLOW_NS;
    localparam int CW_NS  = FAST_GRADE ? T_CW_FAST_NS : T_CW_SLOW_NS;

    localparam int RD_CYC    = minCycles(RD_NS);
    localparam int WP_CYC    = minCycles(WP_NS);
    localparam int SETUP_CYC = minCycles(max2(DIS_NS, T_PD_SETUP_NS));
    // Setup and recovery add to the pulse; the total must meet tcw.
    localparam int WREC_CYC  = max2(1, minCycles(CW_NS) - WP_CYC
                                    - SETUP_CYC);

    localparam logic [TIMER_W-1:0] RD_LOAD    = TIMER_W'(RD_CYC - 1);
    localparam logic [TIMER_W-1:0] WP_LOAD    = TIMER_W'(WP_CYC - 1);
    localparam logic [TIMER_W-1:0] SETUP_LOAD = TIMER_W'(SETUP_CYC - 1);
    localparam logic [TIMER_W-1:0] WREC_LOAD  = TIMER_W'(WREC_CYC - 1);
    localparam logic [TIMER_W-1:0] PD_LOAD    = TIMER_W'(RECOVER_CYC - 1);

    generate
        if (RECOVER_CYC < 1 || RECOVER_CYC > (2 ** TIMER_W)) begin : g_bad
            $error("asr_host: RECOVER_CYC does not fit TIMER_W");
        end
        if (2 ** ADDR_W != DEPTH) begin : g_geom
            $error("asr_host: address width does not match depth");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Phase timer.
    logic                 timerLoad;
    logic [TIMER_W-1:0]   timerValue;
    logic                 timerDone;

    asr_timer #(
        .WIDTH     (TIMER_W)
    ) u_timer (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .load      (timerLoad),
        .loadValue (timerValue),
        .expired   (timerDone)
    );

    ////////////////////////////////////////////////////////////////////////
    // Sequencer.
    asr_state_t  state_r;
    asr_state_t  state_nxt;
    asr_req_t    req_r;
    logic        take;

    assign take     = reqValid && reqReady;
    assign reqReady = (state_r == ST_IDLE) && supplyOk;

    always_comb begin
        state_nxt  = state_r;
        timerLoad  = 1'b0;
        timerValue = '0;
        if (!supplyOk && state_r != ST_PWR_OFF) begin
            // Deselect on the same edge the supply is seen low.
            state_nxt = ST_PWR_OFF;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    if (take && reqIn.write) begin
                        state_nxt  = ST_WR_SETUP;
                        timerLoad  = 1'b1;
                        timerValue = SETUP_LOAD;
                    end else if (take) begin
                        state_nxt  = ST_READ;
                        timerLoad  = 1'b1;
                        timerValue = RD_LOAD;
                    end
                end
                ST_READ: begin
                    if (timerDone) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_WR_SETUP: begin
                    if (timerDone) begin
                        state_nxt  = ST_WR_PULSE;
                        timerLoad  = 1'b1;
                        timerValue = WP_LOAD;
                    end
                end
                ST_WR_PULSE: begin
                    if (timerDone) begin
                        state_nxt  = ST_WR_RECOVER;
                        timerLoad  = 1'b1;
                        timerValue = WREC_LOAD;
                    end
                end
                ST_WR_RECOVER: begin
                    if (timerDone) begin
                        state_nxt = ST_IDLE;
                    end
                end
                ST_PWR_OFF: begin
                    if (supplyOk) begin
                        state_nxt  = ST_PWR_RECOVER;
                        timerLoad  = 1'b1;
                        timerValue = PD_LOAD;
                    end
                end
                ST_PWR_RECOVER: begin
                    if (timerDone) begin
                        state_nxt = ST_IDLE;
                    end
                end
                default: begin
                    state_nxt = ST_PWR_OFF;
                end
            endcase
        end
    end

    // Reset assumes the supply has just come up, so recovery is served first.
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            state_r <= ST_PWR_OFF;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            req_r <= '{write: 1'b0, addr: ADDR_RST, data: DATA_RST};
        end else if (take) begin
            req_r <= reqIn;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Completion and read capture.
    logic finishRead;
    logic finishWrite;

    assign finishRead  = (state_r == ST_READ) && timerDone && supplyOk;
    assign finishWrite = (state_r == ST_WR_RECOVER) && timerDone && supplyOk;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdData <= DATA_RST;
        end else if (finishRead) begin
            // Sampled while the chip is still selected, before any change.
            rdData <= dqIn;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            doneValid <= 1'b0;
            doneWrite <= 1'b0;
        end else begin
            doneValid <= finishRead || finishWrite;
            doneWrite <= finishWrite;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            memReady <= 1'b0;
        end else begin
            memReady <= (state_nxt != ST_PWR_OFF) &&
                        (state_nxt != ST_PWR_RECOVER);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pin drive, registered from the next state so pins switch cleanly.
    asr_pins_t pins_nxt;

    always_comb begin
        pins_nxt               = pins;
        pins_nxt.dqOeN         = DRIVE_OFF;
        pins_nxt.selectOneN    = SEL1_IDLE;
        // Driven low whenever no access runs, so power-down never floats it.
        pins_nxt.selectTwoHigh = SEL2_IDLE;
        pins_nxt.writeStrobeN  = STROBE_OFF;
        pins_nxt.outGateN      = STROBE_OFF;
        case (state_nxt)
            ST_READ: begin
                pins_nxt.addr          = take ? reqIn.addr : req_r.addr;
                pins_nxt.selectOneN    = SEL1_ACTIVE;
                pins_nxt.selectTwoHigh = SEL2_ACTIVE;
                pins_nxt.outGateN      = STROBE_ON;
            end
            ST_WR_SETUP: begin
                // Gate high and strobe high while selecting, so the memory
                // never drives and the strobe falls after the select.
                pins_nxt.addr          = take ? reqIn.addr : req_r.addr;
                pins_nxt.selectOneN    = SEL1_ACTIVE;
                pins_nxt.selectTwoHigh = SEL2_ACTIVE;
            end
            ST_WR_PULSE: begin
                pins_nxt.selectOneN    = SEL1_ACTIVE;
                pins_nxt.selectTwoHigh = SEL2_ACTIVE;
                pins_nxt.writeStrobeN  = STROBE_ON;
                pins_nxt.dqOut         = req_r.data;
                pins_nxt.dqOeN         = DRIVE_ON;
            end
            ST_WR_RECOVER: begin
                // Data held one phase past the strobe rise for hold time.
                pins_nxt.selectOneN    = SEL1_ACTIVE;
                pins_nxt.selectTwoHigh = SEL2_ACTIVE;
                pins_nxt.dqOeN         = DRIVE_ON;
            end
            ST_IDLE, ST_PWR_OFF, ST_PWR_RECOVER: begin
                pins_nxt.dqOeN = DRIVE_OFF;
            end
            default: begin
                pins_nxt.dqOeN = DRIVE_OFF;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pins <= '{addr:          ADDR_RST,
                      dqOut:         DATA_RST,
                      dqOeN:         DRIVE_OFF,
                      selectOneN:    SEL1_IDLE,
                      selectTwoHigh: SEL2_IDLE,
                      writeStrobeN:  STROBE_OFF,
                      outGateN:      STROBE_OFF};
        end else begin
            pins <= pins_nxt;
        end
    end

endmodule : asr_host

`default_nettype wire

// >>> asr_pkg.sv
// Package of constants, timing figures and carrier types for the SRAM host.
`default_nettype none

package asr_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Array geometry.
    localparam int ADDR_W  = 17;
    localparam int DATA_W  = 8;
    localparam int DEPTH   = 131072;

    ////////////////////////////////////////////////////////////////////////
    // System clock.
    localparam int CLK_PERIOD_NS = 100;

    ////////////////////////////////////////////////////////////////////////
    // Timing figures in ns, fast grade then slow grade; power-down recovery in ms.
    localparam int T_CR_FAST_NS       = 55;
    localparam int T_CR_SLOW_NS       = 70;
    localparam int T_ACC_ADDR_FAST_NS = 55;
    localparam int T_ACC_ADDR_SLOW_NS = 70;
    localparam int T_ACC_SEL_FAST_NS  = 55;
    localparam int T_ACC_SEL_SLOW_NS  = 70;
    localparam int T_ACC_OE_FAST_NS   = 30;
    localparam int T_ACC_OE_SLOW_NS   = 35;
    localparam int T_DIS_FAST_NS      = 20;
    localparam int T_DIS_SLOW_NS      = 25;
    localparam int T_CW_FAST_NS       = 55;
    localparam int T_CW_SLOW_NS       = 70;
    localparam int T_WP_FAST_NS       = 45;
    localparam int T_WP_SLOW_NS       = 50;
    localparam int T_SU_AWH_FAST_NS   = 50;
    localparam int T_SU_AWH_SLOW_NS   = 55;
    localparam int T_SU_SEL_FAST_NS   = 50;
    localparam int T_SU_SEL_SLOW_NS   = 55;
    localparam int T_SU_D_FAST_NS     = 25;
    localparam int T_SU_D_SLOW_NS     = 30;
    localparam int T_PD_SETUP_NS      = 0;
    localparam int T_PD_RECOVER_MS    = 5;

    // A least time rounded up to whole cycles, never below one.
    function automatic int minCycles(input int ns);
        int c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction : minCycles

    function automatic int max2(input int a, input int b);
        return (a > b) ? a : b;
    endfunction : max2

    localparam int PD_RECOVER_CYC =
        (T_PD_RECOVER_MS * 1000000) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Pin levels.
    localparam logic SEL1_ACTIVE   = 1'b0;
    localparam logic SEL1_IDLE     = 1'b1;
    localparam logic SEL2_ACTIVE   = 1'b1;
    localparam logic SEL2_IDLE     = 1'b0;
    localparam logic STROBE_ON     = 1'b0;
    localparam logic STROBE_OFF    = 1'b1;
    localparam logic DRIVE_ON      = 1'b0;
    localparam logic DRIVE_OFF     = 1'b1;
    localparam logic [ADDR_W-1:0] ADDR_RST = 17'h00000;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Carriers.
    typedef struct packed {
        logic              write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } asr_req_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dqOut;
        logic              dqOeN;
        logic              selectOneN;
        logic              selectTwoHigh;
        logic              writeStrobeN;
        logic              outGateN;
    } asr_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_READ,
        ST_WR_SETUP,
        ST_WR_PULSE,
        ST_WR_RECOVER,
        ST_PWR_OFF,
        ST_PWR_RECOVER
    } asr_state_t;

endpackage : asr_pkg

`default_nettype wire

// >>> asr_timer.sv
// Loadable down counter that times each phase of the SRAM host.
`default_nettype none

module asr_timer #(
    parameter int WIDTH = 16
) (
    input  wire logic             sys_clk,   // System clock.
    input  wire logic             srst,      // Synchronous reset.
    input  wire logic             load,      // Load a new count.
    input  wire logic [WIDTH-1:0] loadValue, // Cycles left minus one.
    output logic                  expired    // Count has reached zero.
);

    logic [WIDTH-1:0] count_r;

    generate
        if (WIDTH < 1) begin : g_bad_width
            $error("asr_timer: WIDTH must be at least one");
        end
    endgenerate

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count_r <= '0;
        end else if (load) begin
            count_r <= loadValue;
        end else if (count_r != '0) begin
            count_r <= count_r - 1'b1;
        end
    end

    assign expired = (count_r == '0);

endmodule : asr_timer

`default_nettype wire

// >>> asr_host_asserts.sv
// Checker of pin and handshake timing for the SRAM host.
`default_nettype none

module asr_host_asserts
    import asr_pkg::*;
#(
    parameter int RECOVER_CYC = 8
) (
    input wire logic              sys_clk,   // System clock.
    input wire logic              srst,      // Synchronous reset.
    input wire logic              reqValid,  // Request offered.
    input wire asr_pkg::asr_req_t reqIn,     // Request fields.
    input wire logic              reqReady,  // Request taken.
    input wire logic              doneValid, // Access finished.
    input wire logic              doneWrite, // Finished one wrote.
    input wire logic              supplyOk,  // Supply in range.
    input wire logic              memReady,  // Memory usable.
    input wire asr_pkg::asr_pins_t pins      // SRAM pin drive.
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Cycles of good supply since the last loss or reset.
    int upCnt;
    always_ff @(posedge sys_clk) begin
        if (srst || !supplyOk) begin
            upCnt <= 0;
        end else if (upCnt < RECOVER_CYC) begin
            upCnt <= upCnt + 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    addr_hold_a: assert property (
        !pins.writeStrobeN |-> $stable(pins.addr))
        else $error("Address moved during the strobe.");
    sel_setup_a: assert property (disable iff (srst || !supplyOk)
        $rose(pins.writeStrobeN) |-> !pins.selectOneN
            && pins.selectTwoHigh && !$past(pins.selectOneN, 2))
        else $error("Selects not held across the write.");
    host_quiet_a: assert property (
        !pins.outGateN |-> pins.dqOeN)
        else $error("Host drives while the gate is open.");
    host_drive_a: assert property (
        !pins.dqOeN |-> pins.outGateN && !pins.selectOneN)
        else $error("Host drives outside a write.");
    pd_rail_a: assert property (
        !memReady |-> pins.selectOneN && !pins.selectTwoHigh)
        else $error("Selects not parked in power-down.");
    supply_drop_a: assert property (
        !supplyOk |=> pins.selectOneN && !doneValid)
        else $error("Chip still selected after supply loss.");
    recover_wait_a: assert property (
        !pins.selectOneN |-> upCnt >= RECOVER_CYC)
        else $error("Chip selected before recovery ended.");
    read_cycle_a: assert property (
        $fell(pins.outGateN) |-> !pins.selectOneN ##1 $stable(pins.addr))
        else $error("Read cycle too short.");
    read_done_a: assert property (disable iff (srst || !supplyOk)
        reqValid && reqReady && !reqIn.write
            |-> ##[2:3] doneValid && !doneWrite)
        else $error("Read did not finish in time.");
    write_done_a: assert property (disable iff (srst || !supplyOk)
        reqValid && reqReady && reqIn.write
            |-> ##[3:4] doneValid && doneWrite)
        else $error("Write did not finish in time.");
endmodule : asr_host_asserts

`default_nettype wire

// >>> asr_sram_model.sv
// Behavioural byte-wide asynchronous SRAM that answers the host.
`default_nettype none

module asr_sram_model
    import asr_pkg::*;
#(
    parameter bit FAST = 1'b1
) (
    input wire asr_pkg::asr_pins_t          pins,     // Host pin drive.
    input wire logic [asr_pkg::DATA_W-1:0]  dqBus,    // Resolved lines.
    output logic                            memDrive, // Memory drives.
    output logic [asr_pkg::DATA_W-1:0]      memData   // Memory byte.
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int TACC = FAST ? T_ACC_SEL_FAST_NS : T_ACC_SEL_SLOW_NS;
    localparam int TDIS = FAST ? T_DIS_FAST_NS : T_DIS_SLOW_NS;
    localparam int TEN  = FAST ? 5 : 10;

    logic [DATA_W-1:0] mem [DEPTH];
    logic              selOn;
    logic              readOn;
    logic              writeOn;

    assign selOn   = !pins.selectOneN && pins.selectTwoHigh;
    assign writeOn = selOn && !pins.writeStrobeN;
    assign readOn  = selOn && pins.writeStrobeN && !pins.outGateN;

    initial begin
        memDrive = 1'b0;
        memData  = '0;
    end

    // The byte is taken as the three-way overlap ends, if the strobe is then high.
    always @(negedge writeOn) begin
        if (pins.writeStrobeN === 1'b1) begin
            mem[pins.addr] = dqBus;
        end
    end

    // Delayed non-blocking updates keep both processes awake, so a select
    // and an address that change in one time step are never missed.
    always @(readOn) begin
        if (readOn === 1'b1) begin
            memDrive <= #(TEN) 1'b1;
        end else begin
            memDrive <= #(TDIS) 1'b0;
        end
    end

    // Garbage shows until the access time has run, so an early sample fails.
    always @(readOn or pins.addr) begin
        memData = ~mem[pins.addr];
        memData <= #(TACC) mem[pins.addr];
    end
endmodule : asr_sram_model

`default_nettype wire

// >>> asr_host_tb.sv
// Self-checking testbench of the SRAM host with a memory model.
`default_nettype none

module asr_host_tb;
    import asr_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int REC = 8;

    logic              sys_clk;
    logic              srst;
    logic              reqValid;
    logic              reqReady;
    logic              doneValid;
    logic              doneWrite;
    logic              supplyOk;
    logic              memReady;
    logic              memDrive;
    logic              got;
    asr_req_t          reqIn;
    asr_pins_t         pins;
    logic [DATA_W-1:0] rdData;
    logic [DATA_W-1:0] dqIn;
    logic [DATA_W-1:0] memData;
    logic [DATA_W-1:0] lastBus = '0;
    int                mismatches = 0;
    int                compares = 0;
    int                n;
    asr_req_t          rowReq [6];
    logic [DATA_W-1:0] rowExp [6];

    asr_host #(.FAST_GRADE(1'b1), .RECOVER_CYC(REC)) dut (
        .sys_clk(sys_clk), .srst(srst), .reqValid(reqValid),
        .reqIn(reqIn), .reqReady(reqReady), .doneValid(doneValid),
        .doneWrite(doneWrite), .rdData(rdData), .supplyOk(supplyOk),
        .memReady(memReady), .pins(pins), .dqIn(dqIn));

    asr_sram_model #(.FAST(1'b1)) u_mem (
        .pins(pins), .dqBus(dqIn), .memDrive(memDrive),
        .memData(memData));

    // Released lines show a changing pattern, never the last byte.
    assign dqIn = !pins.dqOeN ? pins.dqOut
                : (memDrive ? memData : ~lastBus);
    always @(posedge sys_clk) lastBus <= dqIn;

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        compares++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("MISMATCH %0t %s", $time, msg);
        end
    endtask : check

    task automatic wrap_up;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    task automatic wait_ready;
        n = 0;
        while (reqReady !== 1'b1 && n < 100) begin
            @(negedge sys_clk);
            n++;
        end
        if (reqReady !== 1'b1) begin
            check(1'b0, "timeout waiting ready");
            wrap_up();
        end
    endtask : wait_ready

    task automatic access(input asr_req_t r, output logic ok);
        int i;
        ok = 1'b0;
        reqIn = r;
        reqValid = 1'b1;
        wait_ready();
        @(negedge sys_clk);
        reqValid = 1'b0;
        for (i = 0; i < 8 && ok !== 1'b1; i++) begin
            @(negedge sys_clk);
            ok = doneValid;
        end
    endtask : access

    always @(negedge sys_clk) begin
        if (!pins.dqOeN && memDrive) check(1'b0, "bus contention");
    end

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    initial begin
        srst = 1'b1;
        reqValid = 1'b0;
        reqIn = '0;
        supplyOk = 1'b1;
        rowReq = '{'{1'b1, 17'h1FFFF, 8'hA5}, '{1'b1, 17'h00000, 8'h3C},
                   '{1'b0, 17'h1FFFF, 8'h00}, '{1'b0, 17'h00000, 8'h00},
                   '{1'b1, 17'h00000, 8'hC3}, '{1'b0, 17'h00000, 8'h00}};
        rowExp = '{8'h00, 8'h00, 8'hA5, 8'h3C, 8'h00, 8'hC3};
        repeat (20) @(negedge sys_clk);
        check(pins.selectOneN === SEL1_IDLE && pins.dqOeN === DRIVE_OFF
              && pins.selectTwoHigh === SEL2_IDLE && memReady === 1'b0
              && rdData === DATA_RST, "reset pins");
        srst = 1'b0;
        wait_ready();
        check(n >= REC && memReady === 1'b1, "recovery time");
        for (int k = 0; k < 6; k++) begin
            access(rowReq[k], got);
            check(got === 1'b1 && doneWrite === rowReq[k].write, "done");
            if (!rowReq[k].write) begin
                check(rdData === rowExp[k], "read byte");
            end
        end
        // Back-to-back request, then the supply fails inside the write.
        check(reqReady === 1'b1, "ready with done");
        reqIn = '{1'b1, 17'h00055, 8'h77};
        reqValid = 1'b1;
        @(negedge sys_clk);
        reqValid = 1'b0;
        supplyOk = 1'b0;
        n = 0;
        repeat (3) begin
            @(negedge sys_clk);
            if (doneValid !== 1'b0) n++;
        end
        check(n == 0 && pins.selectOneN === SEL1_IDLE && memReady === 1'b0
              && pins.dqOeN === DRIVE_OFF && reqReady === 1'b0,
              "abort");
        supplyOk = 1'b1;
        wait_ready();
        check(n >= REC, "second recovery");
        access(rowReq[2], got);
        check(got === 1'b1 && rdData === 8'hA5, "data kept");
        wrap_up();
    end
endmodule : asr_host_tb

bind asr_host asr_host_asserts #(.RECOVER_CYC(RECOVER_CYC)) u_chk (
    .sys_clk(sys_clk), .srst(srst), .reqValid(reqValid), .reqIn(reqIn),
    .reqReady(reqReady), .doneValid(doneValid), .doneWrite(doneWrite),
    .supplyOk(supplyOk), .memReady(memReady), .pins(pins));

`default_nettype wire
